// *** design/rrc_caps_port.sv ***
// One port's copy of the upper capability bits
`timescale 1ns/1ps
`include "rrc_regs.svh"

module rrc_caps_port (
  input wire logic clk,
  input wire logic rstn,
  input wire logic wrEn,
  input wire rrc_pkg::rrc_caps_t wrData,
  input wire logic rxLock,
  input wire logic chanValid,
  input wire logic [2:0] chanCaps,
  output rrc_pkg::rrc_caps_t caps
);

  // ============================================================
  // Capability storage
  // Software write wins over a same-cycle channel load, so a
  // write that sets the hold bit is never undone by the channel.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      caps <= `RRC_CAPS_UPPER_RESET;
    end else if (wrEn) begin
      // Written values kept as given
      caps <= wrData; // [RL2]
    end else if (!caps[`RRC_FLD_HOLD] && rxLock && chanValid) begin
      // Auto-load only when not held and lock is seen
      caps[`RRC_FLD_MODE0] <= chanCaps[2]; // [RL4] [RL3]
      caps[`RRC_FLD_FREQ] <= chanCaps[1]; // [RL4]
      caps[`RRC_FLD_EQ] <= chanCaps[0]; // [RL4]
    end
    // Hold set: no channel load, fields stay as written [RL1]
  end

endmodule // rrc_caps_port

// *** design/rrc_caps_top.sv ***
// Remote receiver capability bits 7..4 for two ports, with routing
// Functional notes
// RL1: Hold bit blocks channel auto-load of capabilities.
// RL2: While held, fields keep last software values.
// RL3: Bit 6 is mode field least significant bit.
// RL4: Unheld fields load from channel after lock.
// RL5: Software writing values must also set hold.
// RL6: Bit 5 set sends frequency training pattern.
// RL7: Bit 4 set sends equalization training pattern.
// RL8: Each port owns a copy; select shows second.
// RL9: Port select ignored when secondary address enabled.
`timescale 1ns/1ps
`include "rrc_regs.svh"

module rrc_caps_top (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  input wire logic addrIsSecondary,
  input wire logic second_port_view,
  input wire logic secondary_addr_enable,
  input wire logic [1:0] rxLock,
  input wire logic [1:0] chanValid,
  input wire logic [2:0] chanCaps0,
  input wire logic [2:0] chanCaps1,
  output logic [7:0] regRdData,
  output logic [1:0] hold_remote_caps,
  output logic [1:0] fast_ctrl_chan_mode,
  output logic [1:0] emit_freq_training,
  output logic [1:0] emit_eq_training
);

  // ============================================================
  // Access routing
  rrc_pkg::rrc_port_e target; // Port this access reaches
  logic hitCaps; // Address decodes to the capability register
  logic [1:0] portWr; // Per-port write strobe
  rrc_pkg::rrc_caps_t caps [2]; // Stored bits of each port

  // Secondary address overrides the select bit when enabled
  always_comb begin
    if (secondary_addr_enable) begin
      // Select bit ignored here [RL9]
      target = addrIsSecondary ? rrc_pkg::RRC_PORT1 : rrc_pkg::RRC_PORT0;
    end else begin
      // Primary address steered by the view select [RL9] [RL8]
      target = second_port_view ? rrc_pkg::RRC_PORT1 : rrc_pkg::RRC_PORT0;
    end
  end

  assign hitCaps = (regAddr == `RRC_CAPS_UPPER_ADDR);
  assign portWr = {2{regWrEn & hitCaps}} & target;

  // ============================================================
  // Per-port storage
  // Software must set hold with its own values; nothing here can
  // protect an unheld write from the next channel load; the
  // override sequence remains the software's duty.
  rrc_caps_port u_port0 (
    .clk(clk),
    .rstn(rstn),
    .wrEn(portWr[0]),
    .wrData(regWrData[7:4]),
    .rxLock(rxLock[0]),
    .chanValid(chanValid[0]),
    .chanCaps(chanCaps0),
    .caps(caps[0])
  );

  rrc_caps_port u_port1 (
    .clk(clk),
    .rstn(rstn),
    .wrEn(portWr[1]),
    .wrData(regWrData[7:4]),
    .rxLock(rxLock[1]),
    .chanValid(chanValid[1]),
    .chanCaps(chanCaps1),
    .caps(caps[1])
  );

  // ============================================================
  // Read path
  // Registered answer; bits 3..0 and unmapped addresses read zero
  always_ff @(posedge clk) begin
    if (!rstn) begin
      regRdData <= 8'h00;
    end else if (regRdEn) begin
      if (!hitCaps) begin
        // Unmapped address
        regRdData <= 8'h00;
      end else if (target == rrc_pkg::RRC_PORT1) begin
        // Second port copy shown [RL8]
        regRdData <= {caps[1], 4'h0};
      end else begin
        // First port copy
        regRdData <= {caps[0], 4'h0};
      end
    end
  end

  // ============================================================
  // Field outputs, direct from the stored flops
  // Training requests drive the forward link pattern generators
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      hold_remote_caps[p] = caps[p][`RRC_FLD_HOLD];
      fast_ctrl_chan_mode[p] = caps[p][`RRC_FLD_MODE0]; // [RL3]
      emit_freq_training[p] = caps[p][`RRC_FLD_FREQ]; // [RL6]
      emit_eq_training[p] = caps[p][`RRC_FLD_EQ]; // [RL7]
    end
  end

  // ============================================================
  // Checks
  // Held port ignores a channel update with lock present
  a_hold_blocks_load: // [RL1]
  assert property (@(posedge clk) disable iff (!rstn)
    hold_remote_caps[0] && chanValid[0] && rxLock[0] && !portWr[0]
    |=> $stable(caps[0]))
    else $error("held port 0 caps changed by channel");

  // Values written with hold set survive three idle cycles
  a_held_keep_write: // [RL2]
  assert property (@(posedge clk) disable iff (!rstn)
    portWr[1] && regWrData[`RRC_BIT_HOLD] ##1 (!portWr[1]) [*3]
    |-> caps[1] == $past(regWrData[7:4], 3))
    else $error("held port 1 lost written values");

  // Mode bit 0 is taken from data bit 6
  a_mode_bit_six: // [RL3]
  assert property (@(posedge clk) disable iff (!rstn)
    portWr[0] |=> fast_ctrl_chan_mode[0] == $past(regWrData[6]))
    else $error("mode bit not taken from bit 6");

  // Unheld port with lock takes the channel caps
  a_load_when_free: // [RL4]
  assert property (@(posedge clk) disable iff (!rstn)
    !hold_remote_caps[1] && rxLock[1] && chanValid[1] && !portWr[1]
    |=> caps[1][2:0] == $past(chanCaps1) && !hold_remote_caps[1])
    else $error("port 1 caps not loaded from channel");

  // Without lock nothing but a write may move the bits
  a_no_lock_load: // [RL4]
  assert property (@(posedge clk) disable iff (!rstn)
    !rxLock[0] && !portWr[0] |=> $stable(caps[0]))
    else $error("port 0 caps changed without lock");

  // Training requests come from data bits 5 and 4
  a_freq_eq_bits: // [RL6] [RL7]
  assert property (@(posedge clk) disable iff (!rstn)
    portWr[1] |=> emit_freq_training[1] == $past(regWrData[5])
      && emit_eq_training[1] == $past(regWrData[4]))
    else $error("training request bits mis-stored");

  // Select set on primary address reads the second copy
  a_read_port_one: // [RL8]
  assert property (@(posedge clk) disable iff (!rstn)
    regRdEn && hitCaps && !secondary_addr_enable && second_port_view
    |=> regRdData == {$past(caps[1]), 4'h0})
    else $error("second port view not read back");

  // Secondary enable makes the select bit irrelevant
  a_select_ignored: // [RL9]
  assert property (@(posedge clk) disable iff (!rstn)
    regWrEn && hitCaps && secondary_addr_enable && !addrIsSecondary
    && !chanValid[1] |=> $stable(caps[1]))
    else $error("select bit obeyed under secondary address");

  // Other addresses read back as zero
  a_unmapped_zero:
  assert property (@(posedge clk) disable iff (!rstn)
    regRdEn && !hitCaps |=> regRdData == 8'h00)
    else $error("unmapped read not zero");

  // Reset clears both stored copies and the read register
  a_reset_clears_all:
  assert property (@(posedge clk)
    !rstn |=> regRdData == 8'h00
      && caps[0] == `RRC_CAPS_UPPER_RESET
      && caps[1] == `RRC_CAPS_UPPER_RESET)
    else $error("reset left capability state set");

  // Primary address, select clear: write lands in port 0
  a_primary_to_first: // [RL8]
  assert property (@(posedge clk) disable iff (!rstn)
    regWrEn && hitCaps && !secondary_addr_enable && !second_port_view
    |=> caps[0] == $past(regWrData[7:4]))
    else $error("primary write missed port 0");

  // Primary address, select set: write lands in port 1
  a_view_to_second: // [RL8]
  assert property (@(posedge clk) disable iff (!rstn)
    regWrEn && hitCaps && !secondary_addr_enable && second_port_view
    |=> caps[1] == $past(regWrData[7:4]))
    else $error("view select write missed port 1");

  // Secondary address reaches port 1 whatever the select says
  a_secondary_to_second: // [RL9]
  assert property (@(posedge clk) disable iff (!rstn)
    regWrEn && hitCaps && secondary_addr_enable && addrIsSecondary
    |=> caps[1] == $past(regWrData[7:4]))
    else $error("secondary write missed port 1");

  // Primary address, select clear: first copy read back
  a_read_first_port: // [RL8]
  assert property (@(posedge clk) disable iff (!rstn)
    regRdEn && hitCaps && !secondary_addr_enable && !second_port_view
    |=> regRdData == {$past(caps[0]), 4'h0})
    else $error("first port copy not read back");

  // Primary address under secondary enable reads port 0
  a_read_secondary_off: // [RL9]
  assert property (@(posedge clk) disable iff (!rstn)
    regRdEn && hitCaps && secondary_addr_enable && !addrIsSecondary
    |=> regRdData == {$past(caps[0]), 4'h0})
    else $error("select bit obeyed on read");

  // Writes to other addresses leave port 0's stored bits alone
  a_unmapped_no_write:
  assert property (@(posedge clk) disable iff (!rstn)
    regWrEn && !hitCaps && !chanValid[0] |=> $stable(caps[0]))
    else $error("unmapped write changed port 0");

endmodule // rrc_caps_top

// *** design/rrc_pkg.sv ***
// Types shared by the remote capability register files
package rrc_pkg;

  // ============================================================
  // Port that a register access is steered to, one-hot
  typedef enum logic [1:0] {
    RRC_PORT0 = 2'b01,
    RRC_PORT1 = 2'b10
  } rrc_port_e;

  // Four stored capability bits: hold, mode bit 0, freq, eq
  typedef logic [3:0] rrc_caps_t;

endpackage

// *** design/rrc_regs.svh ***
// Register offsets, field positions and reset values of the capability bits
`ifndef RRC_REGS_SVH
`define RRC_REGS_SVH

// ============================================================
// Register map
// Capability register, upper half (bits 7 to 4)
`define RRC_CAPS_UPPER_ADDR 8'h20
// Reset value of the four stored bits
`define RRC_CAPS_UPPER_RESET 4'h0

// ============================================================
// Field positions inside the full 8-bit register
`define RRC_BIT_HOLD 7
`define RRC_BIT_MODE0 6
`define RRC_BIT_FREQ 5
`define RRC_BIT_EQ 4

// ============================================================
// Field positions inside the stored 4-bit nibble
`define RRC_FLD_HOLD 3
`define RRC_FLD_MODE0 2
`define RRC_FLD_FREQ 1
`define RRC_FLD_EQ 0

`endif

// *** verif/rrc_remote_des.sv ***
// Remote receiver model feeding one port's channel
`timescale 1ns/1ps

// ============================================================
// Lock follows linkUp; push sends one capability update
module rrc_remote_des (
  input wire logic clk,
  input wire logic linkUp,
  output logic lock,
  output logic valid,
  output logic [2:0] caps
);
  assign lock = linkUp; // Lock level set by the bench
  initial valid = 1'b0; // Idle until a push
  initial caps = 3'h5; // Arbitrary idle pattern
  // One-cycle pulse; data inverted after so stale use shows
  task push(input logic [2:0] c);
    @(negedge clk);
    valid = 1'b1;
    caps = c;
    @(negedge clk);
    valid = 1'b0;
    caps = ~c;
  endtask
endmodule // rrc_remote_des

// *** verif/testbench.sv ***
// Self-checking bench for the capability bit bank
`timescale 1ns/1ps

// ============================================================
// Bench top
module testbench;
  logic clk = 1'b0; // 40 MHz clock
  logic rstn = 1'b0; // Sync reset, held low at start
  logic [7:0] regAddr = 8'h00; // Access address
  logic regWrEn = 1'b0; // Write strobe
  logic [7:0] regWrData = 8'h00; // Write data
  logic regRdEn = 1'b0; // Read strobe
  logic addrIsSec = 1'b0; // Access on secondary address
  logic portView = 1'b0; // Second port view select
  logic secEn = 1'b0; // Secondary address enable
  logic [1:0] linkUp = 2'h0; // Lock per port
  wire logic [1:0] lock, valid; // From partner models
  wire logic [2:0] caps0, caps1; // Channel caps
  logic [7:0] rdData; // Read data
  logic [1:0] h, m, f, e; // Field outputs
  wire logic [7:0] pins = {h[1], m[1], f[1], e[1],
    h[0], m[0], f[0], e[0]}; // Port 1 nibble high
  int failures = 0; // Mismatch count
  int cmp_count = 0; // Comparison count

  initial forever #12.5 clk = ~clk; // Half period

  rrc_remote_des p0 (.clk(clk), .linkUp(linkUp[0]),
    .lock(lock[0]), .valid(valid[0]), .caps(caps0));
  rrc_remote_des p1 (.clk(clk), .linkUp(linkUp[1]),
    .lock(lock[1]), .valid(valid[1]), .caps(caps1));
  rrc_caps_top dut (.clk(clk), .rstn(rstn),
    .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn),
    .addrIsSecondary(addrIsSec), .second_port_view(portView),
    .secondary_addr_enable(secEn), .rxLock(lock),
    .chanValid(valid), .chanCaps0(caps0), .chanCaps1(caps1),
    .regRdData(rdData), .hold_remote_caps(h),
    .fast_ctrl_chan_mode(m), .emit_freq_training(f),
    .emit_eq_training(e));

  // Single compare; four-state equality so X never matches
  task chk(input string what, input logic [7:0] exp,
    input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Write strobe for one cycle, driven at falling edge
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge clk);
    regWrEn = 1'b0;
  endtask

  // Read strobe; data registered at the taking edge
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge clk);
    regRdEn = 1'b0;
    chk("regRdData", exp, rdData);
  endtask

  // Counts then verdict, single exit point
  task test_done;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Watchdog well beyond the 44 cycles needed
  initial begin
    #100000;
    failures++;
    test_done;
  end

  // Main sequence
  initial begin
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    rd(8'h20, 8'h00);
    chk("pins", 8'h00, pins);
    $display("test reset done");
    wr(8'h20, 8'hd5); // Low nibble dropped
    chk("pins", 8'h0d, pins);
    rd(8'h20, 8'hd0);
    $display("test write done");
    linkUp = 2'h3;
    p0.push(3'b010); // Port 0 held, so ignored
    chk("pins", 8'h0d, pins);
    p1.push(3'b101);
    chk("pins", 8'h5d, pins);
    portView = 1'b1;
    rd(8'h20, 8'h50);
    wr(8'h20, 8'h10); // Select set: port 1 written
    chk("pins", 8'h1d, pins);
    $display("test channel done");
    secEn = 1'b1; // Select bit now ignored
    rd(8'h20, 8'hd0);
    addrIsSec = 1'b1;
    wr(8'h20, 8'ha0); // Software override sets hold
    chk("pins", 8'had, pins);
    p1.push(3'b000);
    chk("pins", 8'had, pins);
    addrIsSec = 1'b0;
    wr(8'h20, 8'h00); // Release port 0 hold
    p0.push(3'b011);
    chk("pins", 8'ha3, pins);
    wr(8'h21, 8'hff); // Unmapped write dropped
    chk("pins", 8'ha3, pins);
    rd(8'h21, 8'h00);
    rd(8'h20, 8'h30); // Port 0 under secondary routing
    $display("test routing done");
    rstn = 1'b0; // Reset again with state set
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    chk("regRdData", 8'h00, rdData);
    chk("pins", 8'h00, pins);
    rd(8'h20, 8'h00);
    $display("test reset again done");
    test_done;
  end
endmodule // testbench
